/* design/usart_pkg.sv */
// shared constants and state types for the serial character block
package usart_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] MODE_OFS   = 8'h04;
	localparam logic [7:0] IRQ_EN_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h14;
	localparam logic [7:0] RXH_OFS    = 8'h18;
	localparam logic [7:0] TXH_OFS    = 8'h1c;
	localparam logic [7:0] LIMIT_OFS  = 8'h24;
	localparam logic [7:0] GUARD_OFS  = 8'h28;
	// control register command bits
	localparam int CLR_STATUS_POS  = 8;
	localparam int ARM_IDLE_POS    = 11;
	localparam int RELOAD_IDLE_POS = 15;
	localparam int ADDR_MARK_POS   = 19;
	// mode register fields
	localparam int CHAR_LENGTH_FIELD_LSB    = 6;
	localparam int CLOCKED_POS = 8;
	localparam int KIND_LSB    = 9;
	localparam int MSB_FIRST_BIT_POS    = 16;
	localparam int NINE_POS    = 17;
	// status register bits
	localparam int ST_RX_CHAR_READY  = 0;
	localparam int ST_TXFREE = 1;
	localparam int ST_OVR    = 5;
	localparam int ST_PERR   = 7;
	localparam int ST_TOUT   = 8;
	localparam int ST_TXIDLE = 9;
	// check bit kinds, 4 and 5 both mean none, 6 and 7 multidrop
	localparam logic [2:0] KIND_EVEN  = 3'h0;
	localparam logic [2:0] KIND_ODD   = 3'h1;
	localparam logic [2:0] KIND_SPACE = 3'h2;
	localparam logic [2:0] KIND_MARK  = 3'h3;
	localparam logic [1:0] KIND_NONE_HI  = 2'h2;
	localparam logic [1:0] KIND_MDROP_HI = 2'h3;
	// reset values
	localparam logic [17:0] MODE_RST  = 18'h00000;
	localparam logic [15:0] LIMIT_RST = 16'h0000;
	localparam logic [7:0]  GUARD_RST = 8'h00;
	// data bits for a zero length field, and the nine bit length
	localparam logic [3:0] BASE_BITS = 4'h5;
	localparam logic [3:0] NINE_BITS = 4'h9;

	typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
	typedef enum logic [2:0] {
		TX_IDLE, TX_DATA, TX_PAR, TX_STOP, TX_GUARD
	} tx_state_t;
endpackage : usart_pkg

/* design/idle_timer.sv */
// receive idle countdown with arm and reload commands
`timescale 1ns/10ps
module idle_timer #(
	parameter int WIDTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             tick,
	input  wire logic             char_done,
	input  wire logic             arm_cmd,
	input  wire logic             reload_cmd,
	input  wire logic [WIDTH-1:0] limit,
	output logic                  timed_out
);
	localparam logic [WIDTH-1:0] ONE = WIDTH'(1);
	logic [WIDTH-1:0] count;
	logic             running;
	logic             expire;

	assign expire = tick && running && (count == ONE) && (limit != '0);

	// countdown, reloaded by characters and the reload command
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count <= '0;
			running <= 1'b0;
		end else if (limit == '0) begin
			running <= 1'b0;
		end else if (char_done || reload_cmd) begin
			count <= limit;
			running <= 1'b1;
		end else if (arm_cmd) begin
			running <= 1'b0;
		end else if (tick && running) begin
			count <= count - ONE;
			if (count == ONE)
				running <= 1'b0;
		end
	end

	// sticky flag, expiry wins over a same-cycle clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			timed_out <= 1'b0;
		else if (limit == '0)
			timed_out <= 1'b0;
		else if (expire)
			timed_out <= 1'b1;
		else if (arm_cmd || reload_cmd)
			timed_out <= 1'b0;
	end

	zero_limit_a: assert property (@(posedge sys_clk) disable iff (rst)
		limit == '0 |=> !timed_out)
		else $error("time-out flag raised with zero limit");
	expiry_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
		expire |=> timed_out)
		else $error("counter reached zero without flag");
	arm_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		arm_cmd && !char_done && !reload_cmd |=> !running)
		else $error("counter still running after arm command");
endmodule : idle_timer

/* design/usart_char.sv */
// serial character engine: clocked receive, parity, guard time, idle timer
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
module usart_char
	import usart_pkg::*;
#(
	parameter int LIMIT_W = 16
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	input  wire logic        bit_clk,
	input  wire logic        rxd,
	output logic             txd,
	output logic             irq
);
	logic [17:0]        mode_reg;
	logic [7:0]         guard_time_reg;
	logic [LIMIT_W-1:0] rx_idle_limit_reg;
	logic               irq_enable;
	logic [8:0]         rx_holding_reg;
	logic [8:0]         tx_holding_reg;
	logic               rx_char_ready;
	logic               overrun_flag;
	logic               check_bit_error_flag;
	logic               timed_out;
	logic               bit_clk_meta;
	logic               bit_clk_sync;
	logic               bit_clk_last;
	logic               rxd_meta;
	logic               rxd_sync;
	logic               tick;
	rx_state_t          rx_state;
	logic [3:0]         rx_cnt;
	logic [8:0]         rx_shift;
	logic               rx_par_bit;
	logic               rx_done;
	tx_state_t          tx_state;
	logic [3:0]         tx_cnt;
	logic [8:0]         tx_shift;
	logic               tx_addr_bit;
	logic [7:0]         guard_cnt;
	logic               hold_full;
	logic               hold_addr;
	logic               addr_pending;
	logic               tx_holding_free;
	logic               tx_all_idle;
	logic [2:0]         check_bit_kind_field;
	logic [1:0]         char_length_field;
	logic               clocked_mode;
	logic               msb_first_bit;
	logic               nine_bit_option;
	logic               par_used;
	logic [3:0]         char_bits;
	logic [3:0]         tx_idx;
	logic               ctrl_wr;
	logic               clear_status_cmd;
	logic               arm_idle_counter_cmd;
	logic               reload_idle_counter_cmd;
	logic               address_mark_cmd;
	logic               thr_wr;
	logic               rhr_rd;

	// mode fields, shared by both directions except clocked_mode, which only the receiver uses
	assign check_bit_kind_field = mode_reg[KIND_LSB+:3];
	assign char_length_field    = mode_reg[CHAR_LENGTH_FIELD_LSB+:2];
	assign clocked_mode         = mode_reg[CLOCKED_POS];
	assign msb_first_bit        = mode_reg[MSB_FIRST_BIT_POS];
	assign nine_bit_option      = mode_reg[NINE_POS];
	assign par_used  = check_bit_kind_field[2:1] != KIND_NONE_HI;
	assign char_bits = nine_bit_option ? NINE_BITS
		: BASE_BITS + {2'b00, char_length_field};

	// bus decode and control commands
	assign ctrl_wr = wr && (addr == CTRL_OFS);
	assign clear_status_cmd        = ctrl_wr && wdata[CLR_STATUS_POS];
	assign arm_idle_counter_cmd    = ctrl_wr && wdata[ARM_IDLE_POS];
	assign reload_idle_counter_cmd = ctrl_wr && wdata[RELOAD_IDLE_POS];
	assign address_mark_cmd        = ctrl_wr && wdata[ADDR_MARK_POS];
	assign thr_wr = wr && (addr == TXH_OFS);
	assign rhr_rd = rd && (addr == RXH_OFS);

	// expected check bit for even, odd, space and mark
	function automatic logic par_value(input logic [2:0] kind,
			input logic ones, input logic addr_bit);
		case (kind)
			KIND_EVEN:  par_value = ones;
			KIND_ODD:   par_value = ~ones;
			KIND_SPACE: par_value = 1'b0;
			KIND_MARK:  par_value = 1'b1;
			default:    par_value = addr_bit;
		endcase
	endfunction : par_value

	// receive check: mismatch, or a high bit in multidrop
	function automatic logic par_bad(input logic [2:0] kind,
			input logic ones, input logic pbit);
		if (kind[2:1] == KIND_NONE_HI)
			par_bad = 1'b0;
		else if (kind[2:1] == KIND_MDROP_HI)
			par_bad = pbit;
		else
			par_bad = pbit != par_value(kind, ones, 1'b0);
	endfunction : par_bad

	// two-stage synchronisers, then a bit clock rising edge
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bit_clk_meta <= 1'b0;
			bit_clk_sync <= 1'b0;
			bit_clk_last <= 1'b0;
			rxd_meta <= 1'b1;
			rxd_sync <= 1'b1;
		end else begin
			bit_clk_meta <= bit_clk;
			bit_clk_sync <= bit_clk_meta;
			bit_clk_last <= bit_clk_sync;
			rxd_meta <= rxd;
			rxd_sync <= rxd_meta;
		end
	end
	assign tick = bit_clk_sync && !bit_clk_last;

	// software written configuration
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mode_reg <= MODE_RST;
			guard_time_reg <= GUARD_RST;
			rx_idle_limit_reg <= LIMIT_RST;
			irq_enable <= 1'b0;
		end else if (wr) begin
			case (addr)
				MODE_OFS:   mode_reg <= wdata[17:0];
				GUARD_OFS:  guard_time_reg <= wdata[7:0];
				LIMIT_OFS:  rx_idle_limit_reg <= wdata[LIMIT_W-1:0];
				IRQ_EN_OFS: irq_enable <= wdata[0];
				default:    ;
			endcase
		end
	end

	// clocked receiver sequencing
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_state <= RX_IDLE;
			rx_cnt <= 4'h0;
			rx_shift <= 9'h000;
			rx_par_bit <= 1'b0;
		end else if (tick) begin
			case (rx_state)
				RX_IDLE: begin
					if (clocked_mode && !rxd_sync) begin
						rx_state <= RX_DATA;
						rx_cnt <= 4'h0;
						rx_shift <= 9'h000;
					end
				end
				RX_DATA: begin
					if (msb_first_bit)
						rx_shift <= {rx_shift[7:0], rxd_sync};
					else
						rx_shift[rx_cnt] <= rxd_sync;
					rx_cnt <= rx_cnt + 4'h1;
					if (rx_cnt == char_bits - 4'h1)
						rx_state <= par_used ? RX_PAR : RX_STOP;
				end
				RX_PAR: begin
					rx_par_bit <= rxd_sync;
					rx_state <= RX_STOP;
				end
				RX_STOP:  rx_state <= RX_IDLE;
				default:  rx_state <= RX_IDLE;
			endcase
		end
	end
	assign rx_done = tick && (rx_state == RX_STOP);

	// holding register and receive status, set beats clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_holding_reg <= 9'h000;
			rx_char_ready <= 1'b0;
			overrun_flag <= 1'b0;
			check_bit_error_flag <= 1'b0;
		end else begin
			if (rx_done) begin
				rx_holding_reg <= rx_shift;
				rx_char_ready <= 1'b1;
			end else if (rhr_rd)
				rx_char_ready <= 1'b0;
			if (rx_done && rx_char_ready)
				overrun_flag <= 1'b1;
			else if (clear_status_cmd)
				overrun_flag <= 1'b0;
			if (rx_done && par_bad(check_bit_kind_field, ^rx_shift,
					rx_par_bit))
				check_bit_error_flag <= 1'b1;
			else if (clear_status_cmd)
				check_bit_error_flag <= 1'b0;
		end
	end

	// transmit holding register with address marking
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_holding_reg <= 9'h000;
			hold_full <= 1'b0;
			hold_addr <= 1'b0;
			addr_pending <= 1'b0;
		end else begin
			if (thr_wr && !hold_full) begin
				tx_holding_reg <= wdata[8:0];
				hold_full <= 1'b1;
				hold_addr <= addr_pending;
				addr_pending <= 1'b0;
			end else if (address_mark_cmd)
				addr_pending <= 1'b1;
			if (tick && tx_state == TX_IDLE && hold_full)
				hold_full <= 1'b0;
		end
	end

	assign tx_idx = msb_first_bit ? char_bits - 4'h1 - tx_cnt : tx_cnt;

	// transmitter: start, data, check bit, stop, guard gap
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_state <= TX_IDLE;
			tx_cnt <= 4'h0;
			tx_shift <= 9'h000;
			tx_addr_bit <= 1'b0;
			guard_cnt <= 8'h00;
			txd <= 1'b1;
		end else if (tick) begin
			case (tx_state)
				TX_IDLE: begin
					txd <= 1'b1;
					if (hold_full) begin
						txd <= 1'b0;
						tx_shift <= tx_holding_reg & ~(9'h1ff << char_bits);
						tx_addr_bit <= hold_addr;
						tx_cnt <= 4'h0;
						tx_state <= TX_DATA;
					end
				end
				TX_DATA: begin
					txd <= tx_shift[tx_idx];
					tx_cnt <= tx_cnt + 4'h1;
					if (tx_cnt == char_bits - 4'h1)
						tx_state <= par_used ? TX_PAR : TX_STOP;
				end
				TX_PAR: begin
					txd <= par_value(check_bit_kind_field, ^tx_shift,
						tx_addr_bit);
					tx_state <= TX_STOP;
				end
				TX_STOP: begin
					txd <= 1'b1;
					guard_cnt <= guard_time_reg;
					tx_state <= guard_time_reg == 8'h00 ? TX_IDLE
						: TX_GUARD;
				end
				TX_GUARD: begin
					txd <= 1'b1;
					guard_cnt <= guard_cnt - 8'h01;
					if (guard_cnt == 8'h01)
						tx_state <= TX_IDLE;
				end
				default: tx_state <= TX_IDLE;
			endcase
		end
	end
	assign tx_holding_free = !hold_full;
	assign tx_all_idle = tx_state == TX_IDLE && !hold_full;

	idle_timer #(
		.WIDTH(LIMIT_W)
	) u_idle_timer (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.tick      (tick),
		.char_done (rx_done),
		.arm_cmd   (arm_idle_counter_cmd),
		.reload_cmd(reload_idle_counter_cmd),
		.limit     (rx_idle_limit_reg),
		.timed_out (timed_out)
	);

	// interrupt request from the enabled time-out flag
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= timed_out && irq_enable;
	end

	// read data, valid only in the cycle after the strobe
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			rdata <= 32'h00000000;
		else if (rd) begin
			rdata <= 32'h00000000;
			case (addr)
				MODE_OFS:   rdata[17:0] <= mode_reg;
				IRQ_EN_OFS: rdata[0] <= irq_enable;
				GUARD_OFS:  rdata[7:0] <= guard_time_reg;
				LIMIT_OFS:  rdata[LIMIT_W-1:0] <= rx_idle_limit_reg;
				RXH_OFS:    rdata[8:0] <= rx_holding_reg;
				STATUS_OFS: begin
					rdata[ST_RX_CHAR_READY] <= rx_char_ready;
					rdata[ST_TXFREE] <= tx_holding_free;
					rdata[ST_OVR] <= overrun_flag;
					rdata[ST_PERR] <= check_bit_error_flag;
					rdata[ST_TOUT] <= timed_out;
					rdata[ST_TXIDLE] <= tx_all_idle;
				end
				default: ;
			endcase
		end else
			rdata <= 32'h00000000;
	end

	sequence start_seen_s;
		tick && rx_state == RX_IDLE && clocked_mode && !rxd_sync;
	endsequence
	sequence stop_seen_s;
		rx_done ##1 rx_char_ready;
	endsequence

	start_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
		start_seen_s |=> rx_state == RX_DATA)
		else $error("start bit not taken");
	rx_ready_a: assert property (@(posedge sys_clk) disable iff (rst)
		rx_done |-> stop_seen_s)
		else $error("ready not set after character");
	overrun_set_a: assert property (@(posedge sys_clk) disable iff (rst)
		rx_done && rx_char_ready |=> overrun_flag)
		else $error("overrun not flagged");
	overrun_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
		clear_status_cmd && !rx_done |=> !overrun_flag)
		else $error("overrun not cleared");
	no_parity_a: assert property (@(posedge sys_clk) disable iff (rst)
		rx_done && !par_used && !check_bit_error_flag
		|=> !check_bit_error_flag)
		else $error("parity error with parity disabled");
	mark_error_a: assert property (@(posedge sys_clk) disable iff (rst)
		rx_done && check_bit_kind_field == KIND_MARK && !rx_par_bit
		|=> check_bit_error_flag)
		else $error("mark parity error missed");
	guard_high_a: assert property (@(posedge sys_clk) disable iff (rst)
		tx_state == TX_GUARD |-> txd)
		else $error("line low during guard gap");
	guard_busy_a: assert property (@(posedge sys_clk) disable iff (rst)
		tx_state == TX_GUARD |-> !tx_all_idle)
		else $error("idle reported during guard gap");
	free_at_start_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(tx_holding_free) |-> $past(tx_state) == TX_IDLE && !txd)
		else $error("holding freed before start bit");
	irq_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
		timed_out && irq_enable |=> irq)
		else $error("time-out interrupt missing");
endmodule : usart_char

/* tb/remote_dev.sv */
// far-side serial device: sends clocked frames, captures sent ones
`timescale 1ns/10ps
module remote_dev (
	input  wire logic bit_clk,
	input  wire logic txd,
	output logic      rxd
);
	int         n_bits   = 8;
	int         par_used = 1;
	int         cnt      = 0;
	int         gap      = 0;
	int         last_gap = 0;
	int         frames   = 0;
	logic [8:0] got      = 9'h000;
	logic       got_par  = 1'b0;

	// line idles high between frames
	initial rxd = 1'b1;

	// start, data lsb first, optional check bit, one stop
	task automatic send(input logic [8:0] d, input int n, input logic pe,
		input logic p);
		int i;
		@(negedge bit_clk) rxd = 1'b0;
		for (i = 0; i < n; i++) begin
			@(negedge bit_clk) rxd = d[i];
		end
		if (pe) begin
			@(negedge bit_clk) rxd = p;
		end
		@(negedge bit_clk) rxd = 1'b1;
		@(negedge bit_clk);
	endtask : send

	// mid-bit capture of sent frames, idle bits counted between them
	always @(negedge bit_clk) begin
		if (cnt == 0) begin
			if (txd === 1'b0) begin
				cnt = 1;
				last_gap = gap;
			end else begin
				gap++;
			end
		end else begin
			if (cnt <= n_bits) begin
				got[cnt-1] = txd;
			end else begin
				got_par = txd;
			end
			cnt++;
			if (cnt > n_bits + par_used) begin
				cnt = 0;
				gap = 0;
				frames++;
			end
		end
	end
endmodule : remote_dev

/* tb/usart_char_test.sv */
// self-checking bench for the serial character engine
`timescale 1ns/10ps
module usart_char_test;
	import usart_pkg::*;
	localparam int BITP = 16;
	logic        sys_clk    = 1'b0;
	logic        rst        = 1'b1;
	logic [7:0]  addr       = 8'h00;
	logic [31:0] wdata      = 32'h0;
	logic        wr         = 1'b0;
	logic        rd         = 1'b0;
	logic        bit_clk    = 1'b0;
	logic [31:0] rdata;
	logic        rxd;
	logic        txd;
	logic        irq;
	logic [31:0] v;
	int          error_cnt  = 0;
	int          num_checks = 0;

	usart_char #(.LIMIT_W(16)) u_dut (.sys_clk(sys_clk), .rst(rst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.bit_clk(bit_clk), .rxd(rxd), .txd(txd), .irq(irq));
	remote_dev u_far (.bit_clk(bit_clk), .txd(txd), .rxd(rxd));

	// system clock and free-running bit clock
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		forever #(25*BITP) bit_clk = ~bit_clk;
	end

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg

	task automatic chk_w(input string n, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk_w

	task automatic chk_b(input string n, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %b seen %b", n, e, g);
		end
	endtask : chk_b

	task automatic wait_bits(input int n);
		repeat (n * BITP) @(posedge sys_clk);
	endtask : wait_bits

	task automatic wait_frame(input int f);
		int i;
		for (i = 0; i < 1000 && u_far.frames == f; i++) begin
			@(posedge sys_clk);
		end
		chk_w("tx frame count", f + 1, u_far.frames);
	endtask : wait_frame

	// 8 data bits, clocked receive, chosen check bit kind
	function automatic logic [31:0] mode_word(input logic [2:0] k);
		return (32'h3 << CHAR_LENGTH_FIELD_LSB) | (32'h1 << CLOCKED_POS)
			| ({29'h0, k} << KIND_LSB);
	endfunction : mode_word

	function automatic logic exp_par(input logic [2:0] k,
		input logic [7:0] d);
		case (k)
			KIND_EVEN: return ^d;
			KIND_ODD:  return ~^d;
			KIND_MARK: return 1'b1;
			default:   return 1'b0;
		endcase
	endfunction : exp_par

	task automatic reset_values();
		chk_b("txd idle", 1'b1, txd);
		chk_b("irq idle", 1'b0, irq);
		rd_reg(MODE_OFS, v);
		chk_w("mode reset", 32'h0, v);
		rd_reg(STATUS_OFS, v);
		chk_w("status reset", (32'h1 << ST_TXFREE) | (32'h1 << ST_TXIDLE), v);
		rd_reg(8'h30, v);
		chk_w("unmapped read", 32'h0, v);
		rd_reg(LIMIT_OFS, v);
		chk_w("limit reset", 32'h0, v);
	endtask : reset_values

	// every kind, both check bit levels, received
	task automatic rx_parity();
		logic [2:0] k;
		logic       p;
		logic       e;
		logic [7:0] d;
		int         i;
		for (i = 0; i < 16; i++) begin
			k = i[3:1];
			p = i[0];
			d = p ? 8'h43 : 8'h41;
			e = (k[2:1] == KIND_MDROP_HI) ? p
				: (k[2:1] == KIND_NONE_HI) ? 1'b0 : (p != exp_par(k, d));
			wr_reg(MODE_OFS, mode_word(k));
			u_far.send({1'b0, d}, 8, k[2:1] != KIND_NONE_HI, p);
			wait_bits(1);
			rd_reg(STATUS_OFS, v);
			chk_b("rx ready", 1'b1, v[ST_RX_CHAR_READY]);
			chk_b("parity err", e, v[ST_PERR]);
			rd_reg(RXH_OFS, v);
			chk_w("rx holding", {24'h0, d}, v);
			wr_reg(CTRL_OFS, 32'h1 << CLR_STATUS_POS);
			rd_reg(STATUS_OFS, v);
			chk_b("parity err clear", 1'b0, v[ST_PERR]);
		end
	endtask : rx_parity

	task automatic overrun();
		wr_reg(MODE_OFS, mode_word(3'h4));
		u_far.send(9'h011, 8, 1'b0, 1'b0);
		u_far.send(9'h022, 8, 1'b0, 1'b0);
		rd_reg(STATUS_OFS, v);
		chk_b("overrun set", 1'b1, v[ST_OVR]);
		rd_reg(RXH_OFS, v);
		chk_w("rx newest", 32'h22, v);
		wr_reg(CTRL_OFS, 32'h1 << CLR_STATUS_POS);
		rd_reg(STATUS_OFS, v);
		chk_b("overrun clear", 1'b0, v[ST_OVR]);
		chk_b("ready after read", 1'b0, v[ST_RX_CHAR_READY]);
	endtask : overrun

	// msb first short characters, then nine-bit characters, both ways
	task automatic formats();
		int f;
		wr_reg(MODE_OFS, (32'h2 << CHAR_LENGTH_FIELD_LSB) | (32'h1 << CLOCKED_POS)
			| (32'h4 << KIND_LSB) | (32'h1 << MSB_FIRST_BIT_POS));
		u_far.send(9'h069, 7, 1'b0, 1'b0);
		wait_bits(1);
		rd_reg(RXH_OFS, v);
		chk_w("rx msb first", 32'h4b, v);
		u_far.par_used = 0;
		u_far.n_bits = 7;
		f = u_far.frames;
		wr_reg(TXH_OFS, 32'h4b);
		wait_frame(f);
		chk_w("tx msb first", 32'h69, {25'h0, u_far.got[6:0]});
		wait_bits(3);
		wr_reg(MODE_OFS, (32'h1 << CLOCKED_POS) | (32'h4 << KIND_LSB)
			| (32'h1 << NINE_POS));
		u_far.send(9'h1a5, 9, 1'b0, 1'b0);
		wait_bits(1);
		rd_reg(RXH_OFS, v);
		chk_w("rx nine bits", 32'h1a5, v);
		u_far.n_bits = 9;
		f = u_far.frames;
		wr_reg(TXH_OFS, 32'h15a);
		wait_frame(f);
		chk_w("tx nine bits", 32'h15a, {23'h0, u_far.got});
		wait_bits(3);
		u_far.n_bits = 8;
	endtask : formats

	// every kind sent, address mark on kind seven only
	task automatic tx_parity();
		logic [2:0] k;
		int         f;
		int         i;
		for (i = 0; i < 8; i++) begin
			k = i[2:0];
			wr_reg(MODE_OFS, mode_word(k));
			u_far.par_used = (k[2:1] != KIND_NONE_HI);
			if (k == 3'h7) begin
				wr_reg(CTRL_OFS, 32'h1 << ADDR_MARK_POS);
			end
			f = u_far.frames;
			wr_reg(TXH_OFS, 32'h41);
			wait_frame(f);
			chk_w("tx data", 32'h41, {24'h0, u_far.got[7:0]});
			if (k[2:1] == KIND_MDROP_HI) begin
				chk_b("tx mdrop bit", k[0], u_far.got_par);
			end else if (k[2:1] != KIND_NONE_HI) begin
				chk_b("tx check bit", exp_par(k, 8'h41), u_far.got_par);
			end
			wait_bits(3);
			chk_w("line idle", 32'h0, u_far.cnt);
		end
	endtask : tx_parity

	// two back-to-back characters, without and with a guard gap
	task automatic guard_gap();
		int f;
		int g;
		u_far.par_used = 0;
		wr_reg(MODE_OFS, mode_word(3'h4));
		for (g = 0; g <= 2; g += 2) begin
			wr_reg(GUARD_OFS, g);
			f = u_far.frames;
			wr_reg(TXH_OFS, 32'h5a);
			wait_bits(2);
			wr_reg(TXH_OFS, 32'ha5);
			rd_reg(STATUS_OFS, v);
			chk_b("holding busy", 1'b0, v[ST_TXFREE]);
			wait_frame(f);
			rd_reg(STATUS_OFS, v);
			chk_b("free in gap", 1'b0, v[ST_TXFREE]);
			chk_b("idle in gap", 1'b0, v[ST_TXIDLE]);
			wait_frame(f + 1);
			chk_w("second char", 32'ha5, {24'h0, u_far.got[7:0]});
			chk_w("gap bits", g + 1, u_far.last_gap);
			wait_bits(g + 3);
			rd_reg(STATUS_OFS, v);
			chk_b("idle after gap", 1'b1, v[ST_TXIDLE]);
		end
	endtask : guard_gap

	task automatic idle_timeout();
		wr_reg(IRQ_EN_OFS, 32'h1);
		wr_reg(LIMIT_OFS, 32'h5);
		wr_reg(CTRL_OFS, 32'h1 << RELOAD_IDLE_POS);
		wait_bits(3);
		rd_reg(STATUS_OFS, v);
		chk_b("timeout early", 1'b0, v[ST_TOUT]);
		wait_bits(4);
		rd_reg(STATUS_OFS, v);
		chk_b("timeout set", 1'b1, v[ST_TOUT]);
		chk_b("irq set", 1'b1, irq);
		wr_reg(CTRL_OFS, 32'h1 << ARM_IDLE_POS);
		wait_bits(10);
		rd_reg(STATUS_OFS, v);
		chk_b("armed no timeout", 1'b0, v[ST_TOUT]);
		chk_b("irq cleared", 1'b0, irq);
		u_far.send(9'h033, 8, 1'b0, 1'b0);
		wait_bits(2);
		rd_reg(STATUS_OFS, v);
		chk_b("after char early", 1'b0, v[ST_TOUT]);
		wait_bits(4);
		rd_reg(STATUS_OFS, v);
		chk_b("after char set", 1'b1, v[ST_TOUT]);
		wr_reg(LIMIT_OFS, 32'h0);
		wr_reg(CTRL_OFS, 32'h1 << RELOAD_IDLE_POS);
		wait_bits(10);
		rd_reg(STATUS_OFS, v);
		chk_b("disabled timeout", 1'b0, v[ST_TOUT]);
	endtask : idle_timeout

	task automatic tally_and_finish();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish

	// main sequence
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		reset_values();
		rx_parity();
		overrun();
		formats();
		tx_parity();
		guard_gap();
		idle_timeout();
		tally_and_finish();
	end

	// hang guard, well beyond the expected run length
	initial begin
		repeat (60000) @(posedge sys_clk);
		error_cnt++;
		tally_and_finish();
	end
endmodule : usart_char_test
